// *** src/dbc_top.sv ***
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
module dbc_top import dbc_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic dmaInit,
  input wire logic [NUM_SRC-1:0] srcReq,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [NUM_CH-1:0] xferGo,
  output logic [NUM_SRC-1:0] srcClear,
  output logic [NUM_SRC-1:0] cpuSrcReq,
  output logic [NUM_CH-1:0] endIrqReq,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus.

  dbc_reg_if regBus();

  // The bus slave turns channel handshakes into single-cycle strobes.
  dbc_axil_slave uSlave (
    .core_clk(core_clk),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .bus(regBus.slave)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [NUM_CH-1:0] xferEn_ff, nxt_xferEn;
  logic [NUM_CH-1:0] endIe_ff;
  logic [NUM_CH-1:0] armed_ff, nxt_armed;
  logic [15:0] srcSel_ff;
  logic [7:0] mode_ff;
  logic [7:0] stat_ff, nxt_stat;
  logic [7:0] ien_ff;
  logic [NUM_CH-1:0] chDone;
  logic [NUM_CH-1:0] cntLoad;
  logic [CNT_W-1:0] cntLeft [NUM_CH];
  logic [NUM_SRC-1:0] chClear [NUM_CH];
  logic [NUM_SRC-1:0] blockMask;
  logic [NUM_SRC-1:0] clearAll;

  wire [NUM_CH-1:0] ackEn = mode_ff[MODE_ACK_LSB +: NUM_CH];
  wire [NUM_CH-1:0] rptEn = mode_ff[MODE_RPT_LSB +: NUM_CH];
  wire [7:0] bandVal = {xferEn_ff, endIe_ff}; // R1 R2

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.

  // Write strobes for each register; only aligned offsets match.
  wire [ADDR_W-1:0] wAddr = regBus.wrAddr;
  wire [3:0] wStrb = regBus.wrStrb;
  wire [31:0] wData = regBus.wrData;
  wire wrBandHit = (wAddr == OFS_BAND);
  wire wrCntHit = (wAddr[ADDR_W-1:4] == OFS_CNT_BASE[ADDR_W-1:4]) && (wAddr[1:0] == 2'h0);
  wire wrBand = regBus.wrEn & wrBandHit & wStrb[0];
  wire wrSrcSel = regBus.wrEn & (wAddr == OFS_SRCSEL);
  wire wrMode = regBus.wrEn & (wAddr == OFS_MODE) & wStrb[0];
  wire wrClr = regBus.wrEn & (wAddr == OFS_CLR) & wStrb[0];
  wire wrIen = regBus.wrEn & (wAddr == OFS_IEN) & wStrb[0];
  wire [1:0] wCntIdx = wAddr[3:2];
  wire wrCnt = regBus.wrEn & wrCntHit;
  wire [31:0] cntMerged = laneMerge({16'h0000, cntLeft[wCntIdx]}, wData, wStrb);
  wire [31:0] selMerged = laneMerge({16'h0000, srcSel_ff}, wData, wStrb);

  // Unmapped or misaligned writes are refused with an error answer.
  assign regBus.wrHit = wrBandHit | wrCntHit | (wAddr == OFS_SRCSEL) |
                        (wAddr == OFS_MODE) | (wAddr == OFS_CLR) |
                        (wAddr == OFS_STAT) | (wAddr == OFS_IEN);

  // Read decode; the clear register reads as zero.
  wire [ADDR_W-1:0] rAddr = regBus.rdAddr;
  wire rdCntHit = (rAddr[ADDR_W-1:4] == OFS_CNT_BASE[ADDR_W-1:4]) && (rAddr[1:0] == 2'h0);
  wire rdBand = regBus.rdEn & (rAddr == OFS_BAND);
  wire [1:0] rCntIdx = rAddr[3:2];
  assign regBus.rdHit = (rAddr == OFS_BAND) | rdCntHit | (rAddr == OFS_SRCSEL) |
                        (rAddr == OFS_MODE) | (rAddr == OFS_CLR) |
                        (rAddr == OFS_STAT) | (rAddr == OFS_IEN);
  assign regBus.rdData = (rAddr == OFS_BAND) ? {24'h000000, bandVal} :
                         (rAddr == OFS_SRCSEL) ? {16'h0000, srcSel_ff} :
                         (rAddr == OFS_MODE) ? {24'h000000, mode_ff} :
                         (rAddr == OFS_STAT) ? {24'h000000, stat_ff} :
                         (rAddr == OFS_IEN) ? {24'h000000, ien_ff} :
                         rdCntHit ? {16'h0000, cntLeft[rCntIdx]} : 32'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer-enable control.

  // Bits in the written value that ask for a set or a clear.
  wire [NUM_CH-1:0] wrEnBits = wData[XFER_EN_LSB +: NUM_CH];
  wire [NUM_CH-1:0] setReq = wrBand ? (wrEnBits & armed_ff) : '0; // R8
  wire [NUM_CH-1:0] swClear = wrBand ? ~wrEnBits : '0; // R7
  wire [NUM_CH-1:0] hwClear = chDone | {NUM_CH{dmaInit}}; // R5 R6

  // Hardware clears win over a software set in the same cycle.
  assign nxt_xferEn = (xferEn_ff | setReq) & ~swClear & ~hwClear;

  // Reading a zero arms the bit; any write of the register's low byte disarms it.
  // A read in the same cycle as a write keeps the arm.
  wire [NUM_CH-1:0] armSet = rdBand ? ~xferEn_ff : '0; // R8
  assign nxt_armed = armSet | (armed_ff & ~(wrBand ? {NUM_CH{1'b1}} : '0));

  // Band control low register, both halves.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      xferEn_ff <= BAND_RST[XFER_EN_LSB +: NUM_CH]; // R1
      endIe_ff <= BAND_RST[END_IE_LSB +: NUM_CH]; // R2
      armed_ff <= '0;
    end else begin
      xferEn_ff <= nxt_xferEn;
      if (wrBand) endIe_ff <= wData[END_IE_LSB +: NUM_CH]; // R2
      armed_ff <= nxt_armed;
    end
  end

  // Source select, acknowledge and repeat settings.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      srcSel_ff <= SRCSEL_RST;
      mode_ff <= MODE_RST;
    end else begin
      if (wrSrcSel) srcSel_ff <= selMerged[15:0];
      if (wrMode) mode_ff <= wData[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Channels.

  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : gChan
      assign cntLoad[gc] = wrCnt & (wCntIdx == 2'(gc));

      // One sub-channel: request pick-up, count and source clearing.
      dbc_channel uChan (
        .core_clk(core_clk),
        .rst(rst),
        .enable(xferEn_ff[gc]),
        .ackEn(ackEn[gc]),
        .repeatEn(rptEn[gc]),
        .srcSel(selOf(srcSel_ff, gc)),
        .srcReq(srcReq),
        .cntLoad(cntLoad[gc]),
        .cntData(cntMerged[CNT_W-1:0]),
        .xferGo(xferGo[gc]),
        .srcClear(chClear[gc]),
        .done(chDone[gc]),
        .cntLeft(cntLeft[gc])
      );
    end
  endgenerate

  // Sources owned by an enabled, acknowledging channel are hidden from the CPU.
  always_comb begin
    blockMask = '0;
    clearAll = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (xferEn_ff[c] && ackEn[c]) begin
        blockMask[selOf(srcSel_ff, c)] = 1'b1; // R11
      end
      clearAll = clearAll | chClear[c];
    end
  end

  assign srcClear = clearAll; // R11
  assign cpuSrcReq = srcReq & ~blockMask; // R11

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer-end requests and interrupt status.

  // Level request while interrupt enable is on and transfer enable is off.
  assign endIrqReq = endIe_ff & ~xferEn_ff; // R4 R9 R12

  // Completion and forced suspension set sticky status bits.
  wire [NUM_CH-1:0] suspEvt = swClear & xferEn_ff;
  wire [7:0] events = {suspEvt, chDone};
  wire [7:0] clrMask = wrClr ? wData[7:0] : 8'h00;

  // A new event wins over a clear in the same cycle.
  assign nxt_stat = (stat_ff & ~clrMask) | events;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stat_ff <= STAT_RST;
      ien_ff <= IEN_RST;
    end else begin
      stat_ff <= nxt_stat;
      if (wrIen) ien_ff <= wData[7:0];
    end
  end

  // One level interrupt for all enabled status bits.
  assign irq = |(stat_ff & ien_ff);

endmodule

// *** src/dbc_pkg.sv ***
// What this block does
// R1 - Four RW transfer-enable bits 7:4, reset 0.
// R2 - Four RW end-interrupt-enable bits 3:0, reset 0.
// R3 - Enabled channel transfers on selected source requests.
// R4 - Interrupt enable without transfer enable requests interrupt.
// R5 - Initialization clears every transfer-enable bit.
// R6 - Non-repeat mode clears enable after final count.
// R7 - Writing 0 suspends channel and blocks requests.
// R8 - Enable sets only after being read as 0.
// R9 - Interrupt-enable 0 suppresses the end request.
// R10 - Handler withdraws interrupt via enable bits.
// R11 - Enable with acknowledge clears selected source automatically.
// R12 - End request follows the two bits level-wise.
package dbc_pkg;

  // Structure of the block.
  localparam int NUM_CH = 4;
  localparam int NUM_SRC = 16;
  localparam int SEL_W = 4;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_BAND = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SRCSEL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CNT_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CLR = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_IEN = 8'h28;

  // Field positions.
  localparam int XFER_EN_LSB = 4;
  localparam int END_IE_LSB = 0;
  localparam int MODE_ACK_LSB = 0;
  localparam int MODE_RPT_LSB = 4;
  localparam int STAT_END_LSB = 0;
  localparam int STAT_SUSP_LSB = 4;

  // Reset values.
  localparam logic [7:0] BAND_RST = 8'h00;
  localparam logic [15:0] SRCSEL_RST = 16'h0000;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] IEN_RST = 8'h00;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Picks the source-select field of one channel.
  function automatic logic [SEL_W-1:0] selOf(input logic [15:0] sel, input int ch);
    selOf = sel[ch*SEL_W +: SEL_W];
  endfunction

  // Merges write data into an old value under the byte strobes.
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      laneMerge[b*8 +: 8] = strb[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

endpackage

// *** src/dbc_reg_if.sv ***
`timescale 1ns/10ps
interface dbc_reg_if;
  import dbc_pkg::*;

  logic wrEn;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrHit;
  logic rdEn;
  logic [ADDR_W-1:0] rdAddr;
  logic [31:0] rdData;
  logic rdHit;

  modport slave (output wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
                 input wrHit, rdData, rdHit);
  modport regs (input wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
                output wrHit, rdData, rdHit);
endinterface

// *** src/dbc_axil_slave.sv ***
`timescale 1ns/10ps
module dbc_axil_slave import dbc_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  dbc_reg_if.slave bus
);
  logic awHave_ff, wHave_ff, bValid_ff, rValid_ff;
  logic [ADDR_W-1:0] awAddr_ff;
  logic [31:0] wData_ff, rData_ff;
  logic [3:0] wStrb_ff;
  logic [1:0] bResp_ff, rResp_ff;
  wire awTake = s_axi_awvalid & s_axi_awready;
  wire wTake = s_axi_wvalid & s_axi_wready;
  wire doWrite = awHave_ff & wHave_ff & ~bValid_ff;

  // Address and data are held separately, so they may arrive in either order.
  assign s_axi_awready = ~awHave_ff & ~bValid_ff;
  assign s_axi_wready = ~wHave_ff & ~bValid_ff;
  assign s_axi_arready = ~rValid_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;

  // The register file sees one write strobe and one read strobe.
  assign bus.wrEn = doWrite;
  assign bus.wrAddr = awAddr_ff;
  assign bus.wrData = wData_ff;
  assign bus.wrStrb = wStrb_ff;
  assign bus.rdEn = s_axi_arvalid & s_axi_arready;
  assign bus.rdAddr = s_axi_araddr;

  // Write path: capture both halves, then answer once the write is done.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awHave_ff <= 1'b0;
      wHave_ff <= 1'b0;
      awAddr_ff <= '0;
      wData_ff <= 32'h0;
      wStrb_ff <= 4'h0;
      bValid_ff <= 1'b0;
      bResp_ff <= RESP_OKAY;
    end else begin
      if (awTake) awAddr_ff <= s_axi_awaddr;
      if (wTake) wData_ff <= s_axi_wdata;
      if (wTake) wStrb_ff <= s_axi_wstrb;
      awHave_ff <= (awHave_ff | awTake) & ~doWrite;
      wHave_ff <= (wHave_ff | wTake) & ~doWrite;
      bValid_ff <= doWrite | (bValid_ff & ~s_axi_bready);
      if (doWrite) bResp_ff <= bus.wrHit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Read path: data is captured at the address handshake.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rValid_ff <= 1'b0;
      rData_ff <= 32'h0;
      rResp_ff <= RESP_OKAY;
    end else begin
      rValid_ff <= bus.rdEn | (rValid_ff & ~s_axi_rready);
      if (bus.rdEn) rData_ff <= bus.rdData;
      if (bus.rdEn) rResp_ff <= bus.rdHit ? RESP_OKAY : RESP_SLVERR;
    end
  end
endmodule

// *** src/dbc_channel.sv ***
`timescale 1ns/10ps
module dbc_channel import dbc_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic ackEn,
  input wire logic repeatEn,
  input wire logic [SEL_W-1:0] srcSel,
  input wire logic [NUM_SRC-1:0] srcReq,
  input wire logic cntLoad,
  input wire logic [CNT_W-1:0] cntData,
  output logic xferGo,
  output logic [NUM_SRC-1:0] srcClear,
  output logic done,
  output logic [CNT_W-1:0] cntLeft
);
  logic reqPrev_ff;
  logic [CNT_W-1:0] reload_ff;
  logic [CNT_W-1:0] nxt_cnt;

  // A transfer fires on a new request from the selected source while enabled.
  wire selReq = srcReq[srcSel];
  wire fire = enable & selReq & ~reqPrev_ff; // R3 R7
  wire lastOne = (cntLeft == CNT_W'(1));
  wire [NUM_SRC-1:0] clrVec = ackEn ? (NUM_SRC'(1) << srcSel) : '0; // R11

  // Count down per transfer; repeat mode reloads instead of ending.
  assign nxt_cnt = cntLoad ? cntData :
                   !fire ? cntLeft :
                   (lastOne && repeatEn) ? reload_ff : cntLeft - CNT_W'(1);

  // Transfer pulses, source clear and completion all come from flops.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reqPrev_ff <= 1'b0;
      reload_ff <= CNT_RST;
      cntLeft <= CNT_RST;
      xferGo <= 1'b0;
      srcClear <= '0;
      done <= 1'b0;
    end else begin
      reqPrev_ff <= selReq;
      if (cntLoad) reload_ff <= cntData;
      cntLeft <= nxt_cnt;
      xferGo <= fire;
      srcClear <= fire ? clrVec : '0; // R11
      done <= fire & lastOne & ~repeatEn; // R6
    end
  end
endmodule

// *** verif/dbc_chk.sv ***
`timescale 1ns/10ps
// Port-level checks of the channel enable and end-interrupt logic.
module dbc_chk import dbc_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic dmaInit,
  input wire logic [NUM_SRC-1:0] srcReq,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_CH-1:0] xferGo,
  input wire logic [NUM_SRC-1:0] srcClear,
  input wire logic [NUM_SRC-1:0] cpuSrcReq,
  input wire logic [NUM_CH-1:0] endIrqReq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  //////////////////////////////////////////////////////////////////////////////
  // A transfer follows a rising source edge one cycle earlier.
  a_go_src_edge: assert property (|xferGo |-> |($past(srcReq) & ~$past(srcReq, 2)))
    else $error("transfer without a source edge");
  a_go_single: assert property ((xferGo & $past(xferGo)) == 4'h0)
    else $error("transfer pulse longer than one cycle");
  a_clr_with_go: assert property (|srcClear |-> |xferGo)
    else $error("source cleared without a transfer");
  a_cpu_subset: assert property ((cpuSrcReq & ~srcReq) == 16'h0000)
    else $error("cpu request without a source");
  a_init_stops: assert property (dmaInit |-> ##2 xferGo == 4'h0)
    else $error("transfer after initialization");
  a_init_unmask: assert property (dmaInit |=> cpuSrcReq == srcReq)
    else $error("source still masked after initialization");
  a_end_no_go: assert property ((xferGo & $past(endIrqReq)) == 4'h0)
    else $error("transfer on an ended channel");
  a_end_moves: assert property ($changed(endIrqReq) |->
    $rose(s_axi_bvalid) || $past(dmaInit) || ($past(xferGo) != 4'h0))
    else $error("end request moved without a cause");

  //////////////////////////////////////////////////////////////////////////////
  // Bus answers stand until taken.
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
endmodule

bind dbc_top dbc_chk chk (.core_clk(core_clk), .rst(rst), .dmaInit(dmaInit), .srcReq(srcReq),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .xferGo(xferGo), .srcClear(srcClear), .cpuSrcReq(cpuSrcReq),
  .endIrqReq(endIrqReq));

// *** verif/dbc_src_model.sv ***
`timescale 1ns/10ps
// Interrupt source flags of the peripherals that activate the channels.
module dbc_src_model import dbc_pkg::*; (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [NUM_SRC-1:0] fire,
  input wire logic [NUM_SRC-1:0] cpuClr,
  input wire logic [NUM_SRC-1:0] srcClear,
  output logic [NUM_SRC-1:0] srcReq
);
  // A flag rises on an event and falls when the DMA or the CPU clears it.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      srcReq <= '0;
    end else begin
      srcReq <= (srcReq & ~srcClear & ~cpuClr) | fire;
    end
  end
endmodule

// *** verif/test_dma_channel_enable_irq_control.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errCount++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_dma_channel_enable_irq_control import dbc_pkg::*;;
  logic core_clk, rst, dmaInit, irq;
  logic [NUM_SRC-1:0] fire, cpuClr, srcReq, srcClear, cpuSrcReq, clrSeen;
  logic [NUM_CH-1:0] xferGo, endIrqReq, goSeen;
  logic [ADDR_W-1:0] awAddr, arAddr;
  logic [31:0] wData, rData, rdVal;
  logic [3:0] wStrb;
  logic [1:0] bResp, rResp;
  logic awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
  int errCount, checks;

  dbc_top uut (.core_clk(core_clk), .rst(rst), .dmaInit(dmaInit), .srcReq(srcReq),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .xferGo(xferGo), .srcClear(srcClear), .cpuSrcReq(cpuSrcReq), .endIrqReq(endIrqReq),
    .irq(irq));
  dbc_src_model src (.core_clk(core_clk), .rst(rst), .fire(fire), .cpuClr(cpuClr),
    .srcClear(srcClear), .srcReq(srcReq));

  //////////////////////////////////////////////////////////////////////////////
  // Bus write: both halves offered together, each dropped once taken.
  // Handshakes are judged on values that stand before the edge, not on what the edge launches.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic awT, wT, bT;
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(negedge core_clk);
      awT = awValid & awReady;
      wT = wValid & wReady;
      bT = bValid;
      @(posedge core_clk);
      if (awT) awValid <= 1'b0;
      if (wT) wValid <= 1'b0;
    end while (!bT);
    bReady <= 1'b0;
    @(posedge core_clk);
  endtask

  // Bus read with a comparison of data and response.
  task automatic rdChk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic arT, rT;
    logic [1:0] rsp;
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(negedge core_clk);
      arT = arValid & arReady;
      rT = rValid;
      rdVal = rData;
      rsp = rResp;
      @(posedge core_clk);
      if (arT) arValid <= 1'b0;
    end while (!rT);
    rReady <= 1'b0;
    `CHK(rdVal, d)
    `CHK(rsp, r)
    @(posedge core_clk);
  endtask

  // Drops the sources for a cycle, raises them, and gathers the pulses that follow.
  task automatic pulse(input logic [15:0] m);
    cpuClr <= m;
    @(posedge core_clk);
    cpuClr <= '0;
    fire <= m;
    @(posedge core_clk);
    fire <= '0;
    goSeen = '0;
    clrSeen = '0;
    repeat (6) begin
      @(posedge core_clk);
      goSeen = goSeen | xferGo;
      clrSeen = clrSeen | srcClear;
    end
  endtask

  // Prints the verdict and ends the run.
  task finishTest;
    if (errCount == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog.
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #20000;
    errCount++;
    finishTest;
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    {dmaInit, awValid, wValid, bReady, arValid, rReady} = '0;
    {fire, cpuClr, awAddr, arAddr, wData} = '0;
    wStrb = 4'hF;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rdChk(8'h00, 32'h0, RESP_OKAY);
    `CHK(endIrqReq, 4'h0)
    rdChk(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h08, 32'h41);
    wr(8'h04, 32'h3210);
    wr(8'h10, 32'h2);
    wr(8'h14, 32'h3);
    wr(8'h18, 32'h1);
    wr(8'h00, 32'h0F);
    `CHK(endIrqReq, 4'hF)
    wr(8'h00, 32'hFF);
    rdChk(8'h00, 32'h0F, RESP_OKAY);
    wr(8'h00, 32'hFF);
    rdChk(8'h00, 32'hFF, RESP_OKAY);
    `CHK(endIrqReq, 4'h0)
    pulse(16'h0005);
    `CHK(goSeen, 4'h5)
    `CHK(clrSeen, 16'h0001)
    `CHK(cpuSrcReq, 16'h0004)
    pulse(16'h0005);
    `CHK(goSeen, 4'h5)
    rdChk(8'h00, 32'hEF, RESP_OKAY);
    `CHK(endIrqReq, 4'h1)
    rdChk(8'h20, 32'h01, RESP_OKAY);
    `CHK(irq, 1'b0)
    wr(8'h28, 32'h01);
    `CHK(irq, 1'b1)
    wr(8'h24, 32'h01);
    `CHK(irq, 1'b0)
    wr(8'h00, 32'hCE);
    rdChk(8'h00, 32'hCE, RESP_OKAY);
    `CHK(endIrqReq, 4'h2)
    rdChk(8'h20, 32'h20, RESP_OKAY);
    pulse(16'h0002);
    `CHK(goSeen, 4'h0)
    `CHK(cpuSrcReq, 16'h0006)
    dmaInit <= 1'b1;
    @(posedge core_clk);
    dmaInit <= 1'b0;
    repeat (2) @(posedge core_clk);
    rdChk(8'h00, 32'h0E, RESP_OKAY);
    `CHK(endIrqReq, 4'hE)
    finishTest;
  end
endmodule
